// [pai_port.sv]
// port A drive select, pull control and four-pin interrupt detector
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pai_defs.svh"

module pai_port (
    input  wire logic              CLK,      // bus clock, 40 MHz
    input  wire logic              RST,      // async reset, high
    input  wire logic              PSEL,     // apb select
    input  wire logic              PENABLE,  // apb access phase
    input  wire logic              PWRITE,   // apb direction
    input  wire logic [7:0]        PADDR,    // apb byte address
    input  wire logic [31:0]       PWDATA,   // apb write data
    output var  logic [31:0]       PRDATA,   // apb read data
    output var  logic              PREADY,   // apb ready
    output var  logic              PSLVERR,  // apb error, unmapped
    input  wire logic [3:0]        PIN_IN,   // interrupt pin levels
    output var  pai_pkg::pai_pad_t PAD_CTRL, // drive and pull controls
    output var  logic              IRQ       // port interrupt request
);
    import pai_pkg::*;

    pai_ctrl_t   ctrl;
    pai_ctrl_t   next_ctrl;
    logic        flag;
    logic        next_flag;
    logic [3:0]  act_prev;
    logic [3:0]  next_act_prev;
    logic [3:0]  pin_level;
    logic [3:0]  active;
    logic [3:0]  edge_hit;
    logic        event_hit;
    logic        ack_write;
    logic        access;
    logic        bus_write;
    logic        mapped;
    logic [31:0] read_word;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    pai_pad_t    next_pad;
    logic        next_irq;

    // one synchroniser per interrupt pin; pins are not aligned to each other,
    // so two pins that change together may be seen a cycle apart
    pai_sync i_pai_sync_0 (
        .clk   (CLK),
        .rst   (RST),
        .din   (PIN_IN[0]),
        .level (pin_level[0])
    );

    pai_sync i_pai_sync_1 (
        .clk   (CLK),
        .rst   (RST),
        .din   (PIN_IN[1]),
        .level (pin_level[1])
    );

    pai_sync i_pai_sync_2 (
        .clk   (CLK),
        .rst   (RST),
        .din   (PIN_IN[2]),
        .level (pin_level[2])
    );

    pai_sync i_pai_sync_3 (
        .clk   (CLK),
        .rst   (RST),
        .din   (PIN_IN[3]),
        .level (pin_level[3])
    );

    // access phase; ready is withheld one cycle so outputs stay registered
    // a write lands only at the edge where the master sees ready
    assign access    = PSEL & PENABLE;
    assign bus_write = access & PREADY & PWRITE & ~PSLVERR;

    // address decode for the six words
    // anything outside them answers with an error and no effect
    always_comb begin
        mapped = 1'b1;
        unique case (PADDR)
            `PAI_OFF_DRIVE,
            `PAI_OFF_STATCTL,
            `PAI_OFF_PINSEL,
            `PAI_OFF_POLSEL,
            `PAI_OFF_PULLEN,
            `PAI_OFF_DIR: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // read multiplexer; unused upper bits read zero
    // the flag is read live, the acknowledge keeps no state
    always_comb begin
        read_word = `PAI_RST_WORD;
        unique case (PADDR)
            `PAI_OFF_DRIVE: begin
                read_word[7:0] = ctrl.drive;
            end
            `PAI_OFF_STATCTL: begin
                read_word[`PAI_BIT_FLAG] = flag;
                read_word[`PAI_BIT_ACK]  = 1'b0;
                read_word[`PAI_BIT_IE]   = ctrl.irq_enable;
                read_word[`PAI_BIT_MODE] = ctrl.detect_mode;
            end
            `PAI_OFF_PINSEL: begin
                read_word[3:0] = ctrl.pin_sel;
            end
            `PAI_OFF_POLSEL: begin
                read_word[3:0] = ctrl.polarity;
            end
            `PAI_OFF_PULLEN: begin
                read_word[7:0] = ctrl.pull_en;
            end
            `PAI_OFF_DIR: begin
                read_word[7:0] = ctrl.dir;
            end
            default: begin
                read_word = `PAI_RST_WORD;
            end
        endcase
    end

    // bus answer: ready one cycle into the access phase
    // read data holds between reads, so a late sample still sees the word
    always_comb begin
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = PRDATA;
        if (access & ~PREADY) begin
            next_pready  = 1'b1;
            next_pslverr = ~mapped;
            if (~PWRITE) begin
                if (mapped) begin
                    next_prdata = read_word;
                end else begin
                    next_prdata = `PAI_RST_WORD;
                end
            end
        end
    end

    // software writes to the control words
    // flag and ack positions are never stored; ack acts below
    always_comb begin
        next_ctrl = ctrl;
        if (bus_write) begin
            unique case (PADDR)
                `PAI_OFF_DRIVE: begin
                    next_ctrl.drive = PWDATA[7:0] & `PAI_DRIVE_MASK;
                end
                `PAI_OFF_STATCTL: begin
                    next_ctrl.irq_enable  = PWDATA[`PAI_BIT_IE];
                    next_ctrl.detect_mode = PWDATA[`PAI_BIT_MODE];
                end
                `PAI_OFF_PINSEL: begin
                    next_ctrl.pin_sel = PWDATA[3:0];
                end
                `PAI_OFF_POLSEL: begin
                    next_ctrl.polarity = PWDATA[3:0];
                end
                `PAI_OFF_PULLEN: begin
                    next_ctrl.pull_en = PWDATA[7:0];
                end
                `PAI_OFF_DIR: begin
                    next_ctrl.dir = PWDATA[7:0];
                end
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end
    end

    // acknowledge is a write of one to bit 2; the flag bit itself is ignored
    // a one-cycle strobe, so nothing is left to clear later
    assign ack_write = bus_write & (PADDR == `PAI_OFF_STATCTL)
                     & PWDATA[`PAI_BIT_ACK];

    // active level per pin follows its polarity bit
    // polarity 0 means low is active, so an idle pulled-up pin is quiet
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (ctrl.polarity[i]) begin
                active[i] = pin_level[i];
            end else begin
                active[i] = ~pin_level[i];
            end
        end
        next_act_prev = active;
    end

    // edge tracking runs on all pins so enabling a pin starts clean
    // a polarity change can look like an edge; ack after changing it
    assign edge_hit = active & ~act_prev;

    // qualifying event on any selected pin
    // level mode keeps asserting while the pin stays active
    always_comb begin
        event_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (ctrl.pin_sel[i]) begin
                if (edge_hit[i]) begin
                    event_hit = 1'b1;
                end
                if (ctrl.detect_mode & active[i]) begin
                    event_hit = 1'b1;
                end
            end
        end
    end

    // flag: a set in the same cycle as the acknowledge wins
    // else a pin event in the ack cycle would be lost
    always_comb begin
        next_flag = flag;
        if (ack_write) begin
            next_flag = 1'b0;
        end
        if (event_hit) begin
            next_flag = 1'b1;
        end
    end

    // request follows flag and enable together; next values are used
    // so the pin moves in the same cycle as the bits software reads
    always_comb begin
        next_irq = 1'b0;
        if (next_flag & next_ctrl.irq_enable) begin
            next_irq = 1'b1;
        end
    end

    // pad controls; outputs only get drive, inputs only get pulls
    // reset leaves every pin undriven and unpulled
    always_comb begin
        next_pad = '0;
        for (int i = 0; i < 8; i++) begin
            if (next_ctrl.dir[i]) begin
                next_pad.drive_high[i] = next_ctrl.drive[i];
            end
            if (next_ctrl.pull_en[i] & ~next_ctrl.dir[i]) begin
                next_pad.pull_up[i] = 1'b1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (next_pad.pull_up[i] & next_ctrl.pin_sel[i] & next_ctrl.polarity[i]) begin
                next_pad.pull_up[i]   = 1'b0;
                next_pad.pull_down[i] = 1'b1;
            end
        end
    end

    // control registers
    // all clear at reset, so pins start as plain inputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // interrupt flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // previous active levels for edge detection; a false first edge
    // after reset is harmless, as pin select still reads zero then
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            act_prev <= `PAI_RST_NIB;
        end else begin
            act_prev <= next_act_prev;
        end
    end

    // interrupt request pin
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= next_irq;
        end
    end

    // bus handshake outputs, one-cycle pulses
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // read data, held until the next read
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= `PAI_RST_WORD;
        end else begin
            PRDATA <= next_prdata;
        end
    end

    // pad controls
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PAD_CTRL <= '0;
        end else begin
            PAD_CTRL <= next_pad;
        end
    end
endmodule

`default_nettype wire

// [pai_defs.svh]
// register offsets, field positions and reset values of the port A pin interrupt block
`ifndef PAI_DEFS_SVH
`define PAI_DEFS_SVH

// byte offsets on the register bus
`define PAI_OFF_DRIVE   8'h00
`define PAI_OFF_STATCTL 8'h04
`define PAI_OFF_PINSEL  8'h08
`define PAI_OFF_POLSEL  8'h0c
`define PAI_OFF_PULLEN  8'h10
`define PAI_OFF_DIR     8'h14

// status/control field positions
`define PAI_BIT_MODE  0
`define PAI_BIT_IE    1
`define PAI_BIT_ACK   2
`define PAI_BIT_FLAG  3

// drive-select bits that exist (bit 5 is absent)
`define PAI_DRIVE_MASK 8'hdf

// reset values
`define PAI_RST_BYTE 8'h00
`define PAI_RST_NIB  4'h0
`define PAI_RST_WORD 32'h0000_0000

`endif

// [pai_pkg.sv]
// types shared by the port A pin interrupt block
`default_nettype none
package pai_pkg;

    // software-written control state
    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] pull_en;
        logic [7:0] dir;
        logic [3:0] pin_sel;
        logic [3:0] polarity;
        logic       irq_enable;
        logic       detect_mode;
    } pai_ctrl_t;

    // pad controls handed to the port A pads
    typedef struct packed {
        logic [7:0] drive_high;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } pai_pad_t;

endpackage

`default_nettype wire

// [pai_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pai_sync (
    input  wire logic clk,   // bus clock
    input  wire logic rst,   // async reset, high
    input  wire logic din,   // raw pin level
    output var  logic level  // filtered level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // a change counts only once stages two and three agree
    always_comb begin
        next_level = level;
        if (s2 == s3) begin
            next_level = s3;
        end
    end

    // s1 feeds s2 only, so metastability never reaches logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1    <= din;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule

`default_nettype wire

// [pai_port_monitor.sv]
// assertions on the port A pin interrupt block ports
`timescale 1ns/100ps
`default_nettype none
module pai_port_monitor (
    input wire logic              CLK,      // clock
    input wire logic              RST,      // reset
    input wire logic              PSEL,     // select
    input wire logic              PENABLE,  // access
    input wire logic              PWRITE,   // write
    input wire logic [7:0]        PADDR,    // address
    input wire logic [31:0]       PWDATA,   // wdata
    input wire logic [31:0]       PRDATA,   // rdata
    input wire logic              PREADY,   // ready
    input wire logic              PSLVERR,  // error
    input wire pai_pkg::pai_pad_t PAD_CTRL, // pads
    input wire logic              IRQ       // request
);
    import pai_pkg::*;
    // one clock domain, quiet during reset
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_sc_wr; PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h04; endsequence
    property p_one_wait; s_setup |=> !PREADY ##1 PREADY; endproperty
    property p_pulse; PREADY |=> !PREADY; endproperty
    property p_err; PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}); endproperty
    property p_err_ready; PSLVERR |-> PREADY; endproperty
    property p_ack_zero; PREADY && !PWRITE && PADDR == 8'h04 |-> PRDATA[31:4] == 28'h0 && !PRDATA[2]; endproperty
    property p_bit5; !PAD_CTRL.drive_high[5]; endproperty
    property p_pull; (PAD_CTRL.pull_up & PAD_CTRL.pull_down) == 8'h0 && PAD_CTRL.pull_down[7:4] == 4'h0; endproperty
    property p_irq_off; s_sc_wr ##0 !PWDATA[1] |=> !IRQ; endproperty
    property p_irq_hold; IRQ && !(PREADY && PWRITE && PADDR == 8'h04 && (PWDATA[2] || !PWDATA[1])) |=> IRQ; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no single wait state");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_err: assert property (p_err) else $error("error flag wrong");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_ack_zero: assert property (p_ack_zero) else $error("ack reads one");
    a_bit5: assert property (p_bit5) else $error("drive bit 5 active");
    a_pull: assert property (p_pull) else $error("bad pull mix");
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule
bind pai_port pai_port_monitor i_pai_port_monitor (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
                                                   .PRDATA, .PREADY, .PSLVERR, .PAD_CTRL, .IRQ);
`default_nettype wire

// [pai_pins_model.sv]
// far-side model of the four interrupt pins and their pulls
`timescale 1ns/100ps
`default_nettype none
module pai_pins_model (
    input wire logic              clk,    // bus clock
    input wire logic [3:0]        drv_en, // pin driven
    input wire logic [3:0]        drv,    // driven level
    input wire pai_pkg::pai_pad_t pad,    // pull controls
    output var logic [3:0]        pin     // pin levels
);
    import pai_pkg::*;
    logic [3:0] wobble;
    // an open pin has no steady level
    initial wobble = 4'h5;
    always @(posedge clk) wobble <= ~wobble;
    // a pull holds a released pin, else it wanders
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (drv_en[i]) pin[i] = drv[i];
            else if (pad.pull_down[i]) pin[i] = 1'h0;
            else if (pad.pull_up[i]) pin[i] = 1'h1;
            else pin[i] = wobble[i];
        end
    end
endmodule
`default_nettype wire

// [pai_port_tb_top.sv]
// self-checking bench for the port A pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module pai_port_tb_top;
    import pai_pkg::*;
    logic        CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR, IRQ, e;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic [3:0]  PIN_IN, drv = 4'h0;
    pai_pad_t    PAD_CTRL;
    int          fails = 0, checks = 0, cyc = 0;
    pai_port i_pai_port (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
                         .PIN_IN, .PAD_CTRL, .IRQ);
    pai_pins_model i_pai_pins_model (.clk(CLK), .drv_en(4'hf), .drv, .pad(PAD_CTRL), .pin(PIN_IN));
    initial forever #12.5 CLK = ~CLK;
    // hang guard, far beyond the planned run
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until ready is seen, a hang is left to the timeout
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'h1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    // extra edge so pad and irq updates have landed
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0);
        check("read", q, exp);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic summarize();
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'h0;
        for (int a = 0; a < 24; a += 4) rd(a[7:0], 32'h0);
        check("irq", 32'(IRQ), 32'h0);
        // drive select matters only on outputs
        wr(8'h00, 32'hff);
        check("drive", 32'(PAD_CTRL.drive_high), 32'h0);
        rd(8'h00, 32'hdf);
        wr(8'h14, 32'hff);
        check("drive", 32'(PAD_CTRL.drive_high), 32'hdf);
        // pulls only on inputs with pull enable
        wr(8'h08, 32'h3);
        wr(8'h0c, 32'h5);
        wr(8'h10, 32'hff);
        check("pads", 32'(PAD_CTRL), 32'hdf0000);
        wr(8'h14, 32'h0);
        check("pads", 32'(PAD_CTRL), 32'h00fe01);
        wr(8'h10, 32'h0);
        check("pads", 32'(PAD_CTRL), 32'h0);
        // every pin and polarity, edge mode
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                drv <= p ? 4'h0 : 4'hf;
                wr(8'h0c, p ? 32'hf : 32'h0);
                wr(8'h08, 32'h1 << i);
                idle(8);
                wr(8'h04, 32'h6);
                drv[(i + 1) % 4] <= p[0];
                idle(8);
                check("irq", 32'(IRQ), 32'h0);
                drv[i] <= p[0];
                idle(8);
                check("irq", 32'(IRQ), 32'h1);
                wr(8'h04, 32'h2);
                rd(8'h04, 32'ha);
                wr(8'h04, 32'he);
                rd(8'h04, 32'h2);
                check("irq", 32'(IRQ), 32'h0);
            end
        end
        // level mode: a held pin flags again after ack
        wr(8'h04, 32'h7);
        rd(8'h04, 32'hb);
        wr(8'h04, 32'h1);
        check("irq", 32'(IRQ), 32'h0);
        wr(8'h04, 32'h3);
        check("irq", 32'(IRQ), 32'h1);
        drv <= 4'h0;
        idle(8);
        wr(8'h04, 32'h7);
        rd(8'h04, 32'h3);
        // unmapped place answers with error and zero
        xfer(1'h1, 8'h40, 32'hff);
        check("err", 32'(e), 32'h1);
        rd(8'h40, 32'h0);
        check("err", 32'(e), 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
